/* src/strc_pkg.sv */
package strc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNT_L = 3'h2;
  localparam logic [2:0] OFS_CNT_H = 3'h3;
  localparam logic [2:0] OFS_CMPA_L = 3'h4;
  localparam logic [2:0] OFS_CMPA_H = 3'h5;
  localparam logic [2:0] OFS_CMPP = 3'h6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ---------------------------------------------------------------
  // clock select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_HI_DIV16 = 3'h2;
  localparam logic [2:0] CK_HI_DIV64 = 3'h3;
  localparam logic [2:0] CK_TBC = 3'h4;
  localparam logic [2:0] CK_RESERVED = 3'h5;
  localparam logic [2:0] CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CK_EXT_FALL = 3'h7;

  // ---------------------------------------------------------------
  // mode and pin function codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] IO_0 = 2'h0;
  localparam logic [1:0] IO_1 = 2'h1;
  localparam logic [1:0] IO_2 = 2'h2;
  localparam logic [1:0] IO_3 = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } strc_bus_req_t;

  typedef struct packed {
    logic       pause_bit;
    logic [2:0] clock_select_field;
    logic       on_off_bit;
    logic [2:0] unused;
  } strc_ctrl0_t;

  typedef struct packed {
    logic [1:0] operating_mode_field;
    logic [1:0] pin_function_field;
    logic       output_control_bit;
    logic       output_polarity_bit;
    logic       duty_period_select_bit;
    logic       clear_select_bit;
  } strc_ctrl1_t;

endpackage : strc_pkg

/* src/strc_top.sv */
// Functional notes
// - counter readable as low/high byte, read-only
// - compare-A sixteen bits, two RW bytes
// - compare-P eight bits in one RW register
// - pause bit holds counter
// - resume from held value after pause
// - three-bit field selects counter clock
// - reserved clock code stops counter
// - on-bit rising edge zeroes counter
// - on-bit off stops, keeps counter value
// - on rise resets compare output level
// - control0 low three bits read zero
// - two top control1 bits select mode
// - timer/counter mode leaves pin undriven
// - compare-A match acts per pin field
// - PWM pin field: inactive/active/PWM/pulse
// - capture edge per pin field
// - same level match gives no change
// - output-control bit: initial or active level
// - polarity bit inverts output pin
// - duty/period bit swaps compare roles
// - clear-select picks counter clear source in compare and timer modes
`timescale 1ns/1ps
module strc_top
  import strc_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  input  wire strc_bus_req_t i_bus,
  input  wire logic          i_tick_hi_div16,
  input  wire logic          i_tick_hi_div64,
  input  wire logic          i_tick_tbc,
  input  wire logic          i_external_clock_pin,
  input  wire logic          i_capture_input_pin,
  output logic [7:0]         o_rdata,
  output logic               o_timer_output_pin,
  output logic               o_timer_output_oe,
  output logic               o_capture_event,
  output logic               o_powered
);

  // ---------------------------------------------------------------
  // edge selection helper
  // ---------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] kind, input logic rise,
                                    input logic fall);
    logic r;
    r = 1'b0;
    case (kind)
      IO_0:    r = rise;
      IO_1:    r = fall;
      IO_2:    r = rise | fall;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : edge_hit

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  strc_ctrl0_t ctrl0;
  strc_ctrl1_t ctrl1;
  logic [15:0] cnt;
  logic [15:0] compare_a_value;
  logic [7:0]  compare_p_value;
  logic        on_q;
  logic [1:0]  presc;
  logic [2:0]  ext_sync;
  logic [2:0]  cap_sync;
  logic        out_lvl;
  logic        pulse_run;

  logic        on_rise;
  logic        tick;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_rise;
  logic        cap_fall;
  logic        capture_now;
  logic [15:0] cnt_inc;
  logic        hit_a;
  logic        hit_p;
  logic        clr;
  logic [15:0] duty;
  logic        pwm_active;
  logic        wr_c0;

  assign wr_c0 = i_bus.wr && (i_bus.addr == OFS_CTRL0);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      ctrl0 <= strc_ctrl0_t'(RST_BYTE);
    end
    else if (wr_c0)
    begin
      ctrl0 <= strc_ctrl0_t'({i_bus.wdata[7:3], 3'h0});
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      ctrl1 <= strc_ctrl1_t'(RST_BYTE);
    end
    else if (i_bus.wr && (i_bus.addr == OFS_CTRL1))
    begin
      ctrl1 <= strc_ctrl1_t'(i_bus.wdata);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      compare_p_value <= RST_BYTE;
    end
    else if (i_bus.wr && (i_bus.addr == OFS_CMPP))
    begin
      compare_p_value <= i_bus.wdata;
    end
  end

  // capture loads compare-A, a software write in the same cycle wins
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      compare_a_value <= RST_WORD;
    end
    else if (i_bus.wr && (i_bus.addr == OFS_CMPA_L))
    begin
      compare_a_value[7:0] <= i_bus.wdata;
    end
    else if (i_bus.wr && (i_bus.addr == OFS_CMPA_H))
    begin
      compare_a_value[15:8] <= i_bus.wdata;
    end
    else if (capture_now)
    begin
      compare_a_value <= cnt;
    end
  end

  // ---------------------------------------------------------------
  // clock sources
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      presc    <= 2'h0;
      ext_sync <= 3'h0;
      cap_sync <= 3'h0;
      on_q     <= 1'b0;
    end
    else
    begin
      presc    <= presc + 2'h1;
      ext_sync <= {ext_sync[1:0], i_external_clock_pin};
      cap_sync <= {cap_sync[1:0], i_capture_input_pin};
      on_q     <= ctrl0.on_off_bit;
    end
  end

  assign ext_rise = ext_sync[1] & ~ext_sync[2];
  assign ext_fall = ~ext_sync[1] & ext_sync[2];
  assign cap_rise = cap_sync[1] & ~cap_sync[2];
  assign cap_fall = ~cap_sync[1] & cap_sync[2];
  assign on_rise  = ctrl0.on_off_bit & ~on_q;

  always_comb
  begin
    case (ctrl0.clock_select_field)
      CK_SYS_DIV4: tick = (presc == PRESCALE_LAST);
      CK_SYS:      tick = 1'b1;
      CK_HI_DIV16: tick = i_tick_hi_div16;
      CK_HI_DIV64: tick = i_tick_hi_div64;
      CK_TBC:      tick = i_tick_tbc;
      CK_EXT_RISE: tick = ext_rise;
      CK_EXT_FALL: tick = ext_fall;
      default:     tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // compare and clear
  // ---------------------------------------------------------------
  assign cnt_inc = cnt + 16'h0001;
  assign hit_a   = (cnt_inc == compare_a_value);
  assign hit_p   = (cnt_inc == {compare_p_value, 8'h00});

  always_comb
  begin
    if (ctrl1.operating_mode_field == MODE_PWM)
    begin
      clr  = ctrl1.duty_period_select_bit ? hit_a : hit_p;
      duty = ctrl1.duty_period_select_bit ? {compare_p_value, 8'h00}
                                          : compare_a_value;
    end
    else if (ctrl1.operating_mode_field == MODE_CAP)
    begin
      clr  = hit_p;
      duty = compare_a_value;
    end
    else
    begin
      clr  = ctrl1.clear_select_bit ? hit_a : hit_p;
      duty = compare_a_value;
    end
  end

  assign pwm_active = (cnt < duty);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      cnt <= RST_WORD;
    end
    else if (on_rise)
    begin
      cnt <= RST_WORD;
    end
    else if (ctrl0.on_off_bit && !ctrl0.pause_bit && tick)
    begin
      cnt <= clr ? RST_WORD : cnt_inc;
    end
  end

  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  assign capture_now = ctrl0.on_off_bit && (ctrl1.operating_mode_field == MODE_CAP) &&
                       edge_hit(ctrl1.pin_function_field, cap_rise, cap_fall);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_capture_event <= 1'b0;
    end
    else
    begin
      o_capture_event <= capture_now;
    end
  end

  // ---------------------------------------------------------------
  // output level
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      pulse_run <= 1'b0;
    end
    else if (on_rise)
    begin
      pulse_run <= 1'b1;
    end
    else if (!ctrl0.on_off_bit || (tick && !ctrl0.pause_bit && cnt_inc == duty))
    begin
      pulse_run <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      out_lvl <= 1'b0;
    end
    else
    begin
      case (ctrl1.operating_mode_field)
        MODE_CMP:
        begin
          if (on_rise)
          begin
            out_lvl <= ctrl1.output_control_bit;
          end
          else if (ctrl0.on_off_bit && !ctrl0.pause_bit && tick && hit_a)
          begin
            case (ctrl1.pin_function_field)
              IO_1:    out_lvl <= 1'b0;
              IO_2:    out_lvl <= 1'b1;
              IO_3:    out_lvl <= ~out_lvl;
              default: out_lvl <= out_lvl;
            endcase
          end
        end
        MODE_PWM:
        begin
          case (ctrl1.pin_function_field)
            IO_0:    out_lvl <= ~ctrl1.output_control_bit;
            IO_1:    out_lvl <= ctrl1.output_control_bit;
            IO_2:    out_lvl <= (ctrl0.on_off_bit && pwm_active) ? ctrl1.output_control_bit
                                                                : ~ctrl1.output_control_bit;
            default: out_lvl <= pulse_run ? ctrl1.output_control_bit
                                          : ~ctrl1.output_control_bit;
          endcase
        end
        default: out_lvl <= out_lvl;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_timer_output_pin <= 1'b0;
      o_timer_output_oe  <= 1'b0;
      o_powered          <= 1'b0;
    end
    else
    begin
      o_timer_output_pin <= out_lvl ^ ctrl1.output_polarity_bit;
      o_timer_output_oe  <= (ctrl1.operating_mode_field == MODE_CMP) ||
                            (ctrl1.operating_mode_field == MODE_PWM);
      o_powered          <= ctrl0.on_off_bit;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= RST_BYTE;
    end
    else if (i_bus.rd)
    begin
      case (i_bus.addr)
        OFS_CTRL0:  o_rdata <= {ctrl0[7:3], 3'h0};
        OFS_CTRL1:  o_rdata <= ctrl1;
        OFS_CNT_L:  o_rdata <= cnt[7:0];
        OFS_CNT_H:  o_rdata <= cnt[15:8];
        OFS_CMPA_L: o_rdata <= compare_a_value[7:0];
        OFS_CMPA_H: o_rdata <= compare_a_value[15:8];
        OFS_CMPP:   o_rdata <= compare_p_value;
        default:    o_rdata <= RST_BYTE;
      endcase
    end
    else
    begin
      o_rdata <= RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  property p_pause_hold;
    ctrl0.pause_bit && !on_rise |=> $stable(cnt);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("counter moved while paused");

  property p_reserved_hold;
    (ctrl0.clock_select_field == CK_RESERVED) && !on_rise |=> $stable(cnt);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold)
    else $error("counter moved on reserved clock");

  property p_on_rise_zero;
    on_rise |=> (cnt == 16'h0000);
  endproperty
  a_on_rise_zero: assert property (p_on_rise_zero)
    else $error("counter not zero after switch on");

  property p_off_hold;
    !ctrl0.on_off_bit |=> $stable(cnt);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("counter moved while off");

  property p_count_step;
    ctrl0.on_off_bit && !ctrl0.pause_bit && tick && !clr && !on_rise
      |=> (cnt == $past(cnt) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step by one");

  property p_init_level;
    on_rise && (ctrl1.operating_mode_field == MODE_CMP)
      |=> (out_lvl == $past(ctrl1.output_control_bit));
  endproperty
  a_init_level: assert property (p_init_level)
    else $error("output not at initial level");

  property p_ctrl0_low_zero;
    i_bus.rd && (i_bus.addr == OFS_CTRL0) |=> (o_rdata[2:0] == 3'h0);
  endproperty
  a_ctrl0_low_zero: assert property (p_ctrl0_low_zero)
    else $error("unimplemented bits read nonzero");

  property p_cnt_low_read;
    i_bus.rd && (i_bus.addr == OFS_CNT_L) |=> (o_rdata == $past(cnt[7:0]));
  endproperty
  a_cnt_low_read: assert property (p_cnt_low_read)
    else $error("counter low byte read wrong");

  property p_tmr_no_drive;
    (ctrl1.operating_mode_field == MODE_TMR) ##1
      (ctrl1.operating_mode_field == MODE_TMR) |-> !o_timer_output_oe;
  endproperty
  a_tmr_no_drive: assert property (p_tmr_no_drive)
    else $error("pin driven in timer mode");

  property p_polarity;
    ##1 (o_timer_output_pin == ($past(out_lvl) ^ $past(ctrl1.output_polarity_bit)));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pin polarity wrong");

endmodule : strc_top

/* verification/strc_pin_partner.sv */
`timescale 1ns/1ps
module strc_pin_partner
(
  input  wire logic i_clk_sys,
  output logic      o_external_clock_pin,
  output logic      o_capture_input_pin
);
  // ---------------------------------------------------------------
  // pin drivers, changed just after a rising edge
  // ---------------------------------------------------------------
  initial
  begin
    o_external_clock_pin = 1'h0;
    o_capture_input_pin  = 1'h0;
  end

  // n full pulses on the clock pin, each level held gap+1 cycles
  task automatic ext_pulses(input int n, input int gap);
    repeat (2 * n)
    begin
      @(posedge i_clk_sys);
      o_external_clock_pin <= !o_external_clock_pin;
      repeat (gap) @(posedge i_clk_sys);
    end
  endtask : ext_pulses

  // one level change on the capture pin
  task automatic cap_toggle;
    @(posedge i_clk_sys);
    o_capture_input_pin <= !o_capture_input_pin;
  endtask : cap_toggle
endmodule : strc_pin_partner

/* verification/standard_timer_register_control_test.sv */
`timescale 1ns/1ps
module standard_timer_register_control_test import strc_pkg::*;;
  logic          clk, rst_n, t16, t64, ttbc, ext_pin, cap_pin, pin, oe, cap_ev, pwr;
  strc_bus_req_t bus;
  logic [7:0]    rdata, v, m_reg [0:7];
  logic [2:0]    ck [0:3];
  logic [15:0]   m_cnt, w;
  logic          m_lvl, hit;
  int            n_mismatch, cmp_count, seed, k;

  strc_top strc_top_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_bus(bus), .i_tick_hi_div16(t16),
    .i_tick_hi_div64(t64), .i_tick_tbc(ttbc), .i_external_clock_pin(ext_pin),
    .i_capture_input_pin(cap_pin), .o_rdata(rdata), .o_timer_output_pin(pin),
    .o_timer_output_oe(oe), .o_capture_event(cap_ev), .o_powered(pwr));
  strc_pin_partner strc_pin_partner_i (.i_clk_sys(clk), .o_external_clock_pin(ext_pin),
    .o_capture_input_pin(cap_pin));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'h1, 1'h0};
    @(posedge clk);
    bus.wr <= 1'h0;
    @(posedge clk);
    if (a == OFS_CTRL0 && d[3] && !m_reg[0][3])
    begin
      m_cnt = 16'h0000;
      m_lvl = m_reg[1][3];
    end
    if (a != OFS_CNT_L && a != OFS_CNT_H && a != 3'h7)
      m_reg[a] = (a == OFS_CTRL0) ? (d & 8'hF8) : d;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    bus <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk);
    bus.rd <= 1'h0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask : rd

  function automatic logic [7:0] ex(input logic [2:0] a);
    case (a)
      OFS_CNT_L: return m_cnt[7:0];
      OFS_CNT_H: return m_cnt[15:8];
      3'h7: return 8'h00;
      default: return m_reg[a];
    endcase
  endfunction : ex

  task automatic rd_all;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a));
      check($sformatf("reg%0d", a), 16'(v), 16'(ex(3'(a))));
    end
  endtask : rd_all

  // model of one counter clock event
  task automatic step;
    logic [15:0] nx;
    nx = m_cnt + 16'h0001;
    if (m_reg[1][7:6] == MODE_CMP && nx == {m_reg[5], m_reg[4]})
      case (m_reg[1][5:4])
        IO_1: m_lvl = 1'h0;
        IO_2: m_lvl = 1'h1;
        IO_3: m_lvl = !m_lvl;
        default: ;
      endcase
    hit = (m_reg[1][7:6] == MODE_PWM ? m_reg[1][1] : m_reg[1][7:6] != MODE_CAP && m_reg[1][0])
          ? nx == {m_reg[5], m_reg[4]} : nx == {m_reg[6], 8'h00};
    m_cnt = hit ? 16'h0000 : nx;
  endtask : step

  task automatic pulse(input logic [2:0] code, input int n);
    repeat (n)
    begin
      ttbc <= code == CK_TBC || code == CK_RESERVED;
      t16  <= code == CK_HI_DIV16 || code == CK_RESERVED;
      t64  <= code == CK_HI_DIV64 || code == CK_RESERVED;
      @(posedge clk);
      {ttbc, t16, t64} <= 3'h0;
      @(posedge clk);
      if (m_reg[0][3] && !m_reg[0][7] && (m_reg[0][6:4] == code || code == CK_RESERVED) &&
          m_reg[0][6:4] inside {CK_TBC, CK_HI_DIV16, CK_HI_DIV64})
        step();
    end
  endtask : pulse

  task automatic chk_pin(input logic exp_oe, input logic exp_pin);
    @(posedge clk);
    @(negedge clk);
    check("oe", 16'(oe), 16'(exp_oe));
    if (exp_oe)
      check("pin", 16'(pin), 16'(exp_pin));
    check("pwr", 16'(pwr), 16'(m_reg[0][3]));
    @(posedge clk);
  endtask : chk_pin

  // ---------------------------------------------------------------
  // clock and sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #10 clk = !clk;
  end

  initial
  begin
    seed = 55;
    rst_n = 1'h0;
    bus = '0;
    {ttbc, t16, t64} = 3'h0;
    {m_cnt, m_lvl, n_mismatch, cmp_count} = '0;
    ck = '{CK_TBC, CK_HI_DIV16, CK_HI_DIV64, CK_RESERVED};
    for (int a = 0; a < 8; a++)
      m_reg[a] = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd_all();
    repeat (4)
    begin
      for (int a = 1; a < 8; a++)
        wr(3'(a), 8'($random(seed)));
      wr(OFS_CTRL0, 8'($random(seed)) & 8'hF7);
      rd_all();
    end
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, {MODE_TMR, 6'h00});
    wr(OFS_CMPP, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CTRL0, {1'h0, ck[i], 1'h1, 3'h0});
      for (int j = 0; j < 4; j++)
        pulse(ck[j], 2);
      rd_all();
      wr(OFS_CTRL0, {1'h1, ck[i], 1'h1, 3'h0});
      pulse(ck[i], 3);
      rd_all();
      wr(OFS_CTRL0, {1'h0, ck[i], 1'h1, 3'h0});
      pulse(ck[i], 3);
      wr(OFS_CTRL0, {1'h0, ck[i], 1'h0, 3'h0});
      pulse(ck[i], 2);
      rd_all();
    end
    for (int c = 6; c < 8; c++)
    begin
      wr(OFS_CTRL0, {1'h0, 3'(c), 1'h1, 3'h0});
      strc_pin_partner_i.ext_pulses(3, 4);
      repeat (5) @(posedge clk);
      repeat (3) step();
      rd_all();
      wr(OFS_CTRL0, 8'h00);
    end
    for (int c = 0; c < 2; c++)
    begin
      wr(OFS_CTRL0, {1'h0, 3'(c), 1'h1, 3'h0});
      repeat (40) @(posedge clk);
      wr(OFS_CTRL0, {1'h1, 3'(c), 1'h1, 3'h0});
      rd(OFS_CNT_L);
      check("sysclk", 16'(c ? (v >= 37 && v <= 45) : (v >= 6 && v <= 14)), 16'h1);
      m_cnt = {8'h00, v};
      rd_all();
      wr(OFS_CTRL0, 8'h00);
    end
    wr(OFS_CMPP, 8'h01);
    wr(OFS_CTRL0, {1'h0, CK_TBC, 1'h1, 3'h0});
    pulse(CK_TBC, 258);
    rd_all();
    wr(OFS_CMPP, 8'h00);
    wr(OFS_CMPA_L, 8'h03);
    wr(OFS_CMPA_H, 8'h00);
    for (k = 0; k < 16; k++)
    begin
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL1, {MODE_CMP, k[1:0], k[2], k[3], 2'h1});
      wr(OFS_CTRL0, {1'h0, CK_TBC, 1'h1, 3'h0});
      chk_pin(1'h1, m_lvl ^ k[3]);
      repeat (2)
      begin
        pulse(CK_TBC, 3);
        chk_pin(1'h1, m_lvl ^ k[3]);
      end
      rd_all();
    end
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, {MODE_TMR, 6'h3C});
    wr(OFS_CTRL0, {1'h0, CK_TBC, 1'h1, 3'h0});
    chk_pin(1'h0, 1'h0);
    wr(OFS_CMPA_L, 8'h02);
    for (k = 0; k < 32; k++)
    begin
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL1, {MODE_PWM, k[1:0], k[2], k[3], k[4], 1'h0});
      wr(OFS_CTRL0, {1'h0, CK_TBC, 1'h1, 3'h0});
      @(posedge clk);
      chk_pin(1'h1, (k[1:0] != 2'h0 && !(k[1:0] == 2'h2 && k[4]) ? k[2] : !k[2]) ^ k[3]);
      pulse(CK_TBC, 2);
      chk_pin(1'h1, (k[1:0] == 2'h1 || (k[1:0] == 2'h3 && k[4]) ? k[2] : !k[2]) ^ k[3]);
    end
    for (k = 0; k < 4; k++)
    begin
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CTRL1, {MODE_CAP, k[1:0], 4'h0});
      wr(OFS_CTRL0, {1'h0, CK_TBC, 1'h1, 3'h0});
      pulse(CK_TBC, k + 5);
      for (int e = 0; e < 2; e++)
      begin
        wr(OFS_CMPA_L, 8'h00);
        wr(OFS_CMPA_H, 8'h00);
        strc_pin_partner_i.cap_toggle();
        w = 16'h0000;
        repeat (10)
        begin
          @(negedge clk);
          w = w + 16'(cap_ev);
        end
        @(posedge clk);
        check("capev", w, 16'(k == 2 || k == e));
        if (k == 2 || k == e)
          {m_reg[5], m_reg[4]} = m_cnt;
        rd_all();
      end
    end
    conclude();
  end
endmodule : standard_timer_register_control_test
